// ===== src/twcp_pkg.sv
// Package: constants and types of the two-wire command port
package twcp_pkg;

  // ==========================================================
  // Command words
  localparam logic [15:0] PORT_RESET_WORD   = 16'h8D00;
  localparam logic [15:0] PORT_RELEASE_WORD = 16'h8D02;
  localparam logic [15:0] CORE_RESET_WORD   = 16'hBD01;
  localparam int          CMD_BITS          = 16;
  localparam int          PREAMBLE_BITS     = 32;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS    = 100;
  localparam int STEP_FINE_MS     = 1;
  localparam int STEP_COARSE_MS   = 10;
  localparam int CAL_TIME_US      = 1000;
  localparam int MS_CYCLES        = 1000000 / CLK_PERIOD_NS;
  localparam int CAL_CYCLES       = (CAL_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam logic [3:0] STOP_SEL_RESET = 4'h0;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    TWCP_SLEEP,
    TWCP_CAL,
    TWCP_ACTIVE
  } twcp_state_type;

  typedef struct packed {
    logic portReset;
    logic portRelease;
    logic coreReset;
  } twcp_cmd_type;

endpackage

// ===== src/twcp_port.sv
// Two-wire command port: bit sampler, command decode, trigger and sleep control
`timescale 1ns/1ps
module twcp_port
  import twcp_pkg::*;
#(
  parameter int MS_COUNT  = MS_CYCLES,
  parameter int CAL_COUNT = CAL_CYCLES
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // Two-wire pins
  input  wire logic       linkClk,
  input  wire logic       linkData,
  // Configuration
  input  wire logic       startOnFall,
  input  wire logic [3:0] stopSelect,
  // Status and core control
  output logic            triggerEnabled,
  output logic            coreResetPulse,
  output logic            calibrating,
  output logic            transmitting,
  output logic            asleep,
  output twcp_cmd_type    cmdSeen
);

  // ==========================================================
  // Pin synchronisers
  logic [1:0] clkSync;
  logic [1:0] dataSync;
  logic       clkLast;
  logic       dataLast;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      clkSync  <= 2'h3;
      dataSync <= 2'h0;
      clkLast  <= 1'b1;
      dataLast <= 1'b0;
    end else begin
      clkSync  <= {clkSync[0], linkClk};
      dataSync <= {dataSync[0], linkData};
      clkLast  <= clkSync[1];
      dataLast <= dataSync[1];
    end
  end

  logic clkFall;
  logic dataRise;
  logic dataFall;
  assign clkFall  = clkLast & ~clkSync[1];
  assign dataRise = ~dataLast & dataSync[1];
  assign dataFall = dataLast & ~dataSync[1];

  // ==========================================================
  // Shifter and decode
  logic [15:0]  shiftReg;
  logic [15:0]  next_shiftReg;
  twcp_cmd_type decoded;
  always_comb begin
    next_shiftReg = shiftReg;
    if (clkFall) begin
      next_shiftReg = {shiftReg[14:0], dataSync[1]};
    end
  end
  // Sliding compare: the 32 low preamble bits never match a code, so
  // a port reset is recognised on its 48th bit without counting.
  logic [15:0] word;
  assign word = next_shiftReg;
  always_comb begin
    decoded.portReset   = clkFall && word == PORT_RESET_WORD;
    decoded.portRelease = clkFall && word == PORT_RELEASE_WORD;
    decoded.coreReset   = clkFall && word == CORE_RESET_WORD;
  end

  // ==========================================================
  // Port and core state
  twcp_state_type state;
  twcp_state_type next_state;
  logic           next_triggerEnabled;
  logic [31:0]    timer;
  logic [31:0]    next_timer;
  logic [31:0]    stopCycles;
  logic [31:0]    calCount;
  logic [31:0]    msCount;
  logic [7:0]     stopMs;

  assign calCount = 32'(CAL_COUNT);
  assign msCount  = 32'(MS_COUNT);
  // Codes 0..7 give 2..9 ms, 8..15 give 20..90 ms (15 saturates)
  always_comb begin
    if (stopSelect < 4'h8) begin
      stopMs = 8'(2 + 32'(stopSelect) * STEP_FINE_MS);
    end else if (stopSelect < 4'hF) begin
      stopMs = 8'(20 + (32'(stopSelect) - 8) * STEP_COARSE_MS);
    end else begin
      stopMs = 8'h5A;
    end
  end
  assign stopCycles = 32'(stopMs) * msCount;

  always_comb begin
    next_state          = state;
    next_timer          = timer;
    next_triggerEnabled = triggerEnabled;
    // Port reset touches nothing but the port
    if (decoded.portReset) begin
      next_triggerEnabled = 1'b0;
    end else if (decoded.portRelease) begin
      next_triggerEnabled = 1'b1;
    end
    // Unmatched words fall through with no effect
    if (decoded.coreReset) begin
      next_state = TWCP_CAL;
      next_timer = 32'h0;
    end else begin
      case (state)
        TWCP_SLEEP: begin
          if (triggerEnabled && ((startOnFall && dataFall) || (!startOnFall && dataRise))) begin
            next_state = TWCP_ACTIVE;
            next_timer = 32'h0;
          end
        end
        TWCP_CAL: begin
          if (timer >= calCount - 32'h1) begin
            next_state = TWCP_SLEEP;
            next_timer = 32'h0;
          end else begin
            next_timer = timer + 32'h1;
          end
        end
        TWCP_ACTIVE: begin
          if (dataSync[1]) begin
            next_timer = 32'h0;
          end else if (timer >= stopCycles - 32'h1) begin
            next_state = TWCP_SLEEP;
            next_timer = 32'h0;
          end else begin
            next_timer = timer + 32'h1;
          end
        end
        default: begin
          next_state = TWCP_SLEEP;
          next_timer = 32'h0;
        end
      endcase
    end
  end

  // Shifter is part of the port and survives core reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      shiftReg       <= 16'hFFFF;
      state          <= TWCP_SLEEP;
      timer          <= 32'h0;
      triggerEnabled <= 1'b1;
      coreResetPulse <= 1'b0;
      calibrating    <= 1'b0;
      transmitting   <= 1'b0;
      asleep         <= 1'b1;
      cmdSeen        <= '0;
    end else begin
      shiftReg       <= next_shiftReg;
      state          <= next_state;
      timer          <= next_timer;
      triggerEnabled <= next_triggerEnabled;
      coreResetPulse <= decoded.coreReset;
      calibrating    <= next_state == TWCP_CAL;
      transmitting   <= next_state == TWCP_ACTIVE;
      asleep         <= next_state == TWCP_SLEEP;
      cmdSeen        <= decoded;
    end
  end

endmodule

// ===== tb/twcp_monitor.sv
// Checker on the command port outputs
`timescale 1ns/1ps
module twcp_monitor
  import twcp_pkg::*;
(
  // Clock and reset
  input wire logic         ref_clk,
  input wire logic         sys_rst,
  // Status
  input wire logic         triggerEnabled,
  input wire logic         coreResetPulse,
  input wire logic         calibrating,
  input wire logic         transmitting,
  input wire logic         asleep,
  input wire twcp_cmd_type cmdSeen
);
  // ====================
  // Assertions
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  sequence calEnd;
    $fell(calibrating);
  endsequence
  rel_arm_a: assert property (cmdSeen.portRelease |-> ##[0:1] triggerEnabled)
    else $error("trigger not armed");
  rst_block_a: assert property (cmdSeen.portReset |-> ##[0:1] !triggerEnabled)
    else $error("trigger not blocked");
  core_pulse_a: assert property (cmdSeen.coreReset |-> ##[0:1] coreResetPulse)
    else $error("no core pulse");
  cal_start_a: assert property (coreResetPulse |-> ##[0:1] calibrating)
    else $error("no calibration");
  cal_sleep_a: assert property (calEnd |-> ##[0:1] asleep)
    else $error("no sleep after calibration");
  tx_excl_a: assert property (transmitting |-> !asleep)
    else $error("asleep while sending");
  start_gate_a: assert property ($rose(transmitting) |-> $past(triggerEnabled))
    else $error("start while blocked");
  cmd_pulse_a: assert property (cmdSeen != 3'h0 |=> cmdSeen == 3'h0)
    else $error("decode pulse too long");
endmodule

// ===== tb/twcp_host.sv
// Host model on the two-wire pins
`timescale 1ns/1ps
module twcp_host (
  // Pins
  output logic linkClk,
  output logic linkData
);
  initial begin
    linkClk = 1'b0;
    linkData = 1'b0;
  end
  // Clock stands still between frames; high while data drives the transmitter
  task automatic send(input logic [47:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      linkClk = 1'b1;
      linkData = w[i];
      // First fall 400 ns after data moves, inside 20 ns..15 us
      #400 linkClk = 1'b0;
      #400;
    end
    linkData = 1'b0;
  endtask
  task automatic level(input logic v);
    linkClk = 1'b1;
    linkData = v;
  endtask
endmodule

// ===== tb/tb_two_wire_command_port.sv
// Testbench of the two-wire command port
`timescale 1ns/1ps
module tb_two_wire_command_port import twcp_pkg::*;;
  typedef struct {logic [47:0] w; int n; logic [2:0] cmd; logic trg;} twcp_row_type;
  logic         ref_clk = 1'b0;
  logic         sys_rst = 1'b1;
  logic         linkClk, linkData, triggerEnabled, coreResetPulse, calibrating, transmitting, asleep;
  twcp_cmd_type cmdSeen;
  logic [2:0]   seen = 3'h0;
  logic         startOnFall = 1'b0;
  logic [3:0]   stopSelect = 4'h0;
  int           n_fail = 0;
  int           cmp_count = 0;
  twcp_row_type rows[4] = '{
    '{{32'h0, PORT_RESET_WORD}, 48, 3'h4, 1'b0},
    '{48'h1234, 16, 3'h0, 1'b0},
    '{{32'h0, PORT_RELEASE_WORD}, 16, 3'h2, 1'b1},
    '{{32'h0, CORE_RESET_WORD}, 16, 3'h1, 1'b1}};
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) seen <= seen | cmdSeen;
  twcp_port #(.MS_COUNT(10), .CAL_COUNT(20)) dut_u (.ref_clk, .sys_rst, .linkClk, .linkData,
    .startOnFall, .stopSelect, .triggerEnabled, .coreResetPulse, .calibrating,
    .transmitting, .asleep, .cmdSeen);
  twcp_host host_u (.linkClk, .linkData);
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    cyc(5);
    sys_rst = 1'b0;
    chk("reset", 4'h3, {2'h0, asleep, triggerEnabled});
    cyc(3);
    // Rows: port reset, unknown word, release, core reset (power-up order)
    foreach (rows[i]) begin
      seen = 3'h0;
      host_u.send(rows[i].w, rows[i].n);
      cyc(8);
      chk("cmd", {1'h0, rows[i].cmd}, {1'h0, seen});
      chk("trig", {3'h0, rows[i].trg}, {3'h0, triggerEnabled});
    end
    chk("cal", 4'h1, {3'h0, calibrating});
    cyc(25);
    chk("sleep", 4'h1, {2'h0, calibrating, asleep});
    host_u.level(1'b1);
    cyc(10);
    chk("tx", 4'h2, {2'h0, transmitting, asleep});
    host_u.level(1'b0);
    cyc(15);
    chk("hold", 4'h1, {3'h0, transmitting});
    cyc(15);
    chk("stop", 4'h1, {2'h0, transmitting, asleep});
    // Data bits of the command itself may start a burst; let it stop first
    host_u.send({32'h0, PORT_RESET_WORD}, 48);
    cyc(30);
    chk("idle", 4'h1, {2'h0, transmitting, asleep});
    host_u.level(1'b1);
    cyc(10);
    chk("blocked", 4'h0, {2'h0, transmitting, triggerEnabled});
    // Falling-edge start with a coarse stop interval
    host_u.send({32'h0, PORT_RELEASE_WORD}, 16);
    cyc(8);
    chk("rearm", 4'h1, {3'h0, triggerEnabled});
    startOnFall = 1'b1;
    stopSelect = 4'h8;
    host_u.level(1'b1);
    cyc(10);
    chk("rise ign", 4'h1, {2'h0, transmitting, asleep});
    host_u.level(1'b0);
    cyc(10);
    chk("fall tx", 4'h2, {2'h0, transmitting, asleep});
    cyc(150);
    chk("coarse hold", 4'h1, {3'h0, transmitting});
    cyc(70);
    chk("coarse stop", 4'h1, {2'h0, transmitting, asleep});
    results();
  end
endmodule
bind twcp_port twcp_monitor mon_u (.ref_clk, .sys_rst, .triggerEnabled, .coreResetPulse,
  .calibrating, .transmitting, .asleep, .cmdSeen);
